/* verilog/stio_map.vh */
`ifndef STIO_MAP_VH
`define STIO_MAP_VH

// register byte offsets
`define STIO_PORT_MODE   8'h00
`define STIO_OUT_BYTE    8'h04
`define STIO_OUT_SET     8'h08
`define STIO_OUT_CLR     8'h0c
`define STIO_IN_LEVELS   8'h10
`define STIO_IN_SEL      8'h14
`define STIO_ACC_FWD     8'h18
`define STIO_ACC_REV     8'h1c
`define STIO_DIRECTION   8'h20
`define STIO_SEQ_OUT_CFG 8'h24
`define STIO_SWEEP       8'h28
`define STIO_BRANCH_CMD  8'h30
`define STIO_SEQ_STATE   8'h34
`define STIO_SLOTS       8'h38

// reset values and range limits
`define STIO_ACC_RST     3'h7
`define STIO_SEL_MAX     3'h4
`define STIO_SLOT_MIN    3'h1
`define STIO_SLOT_MAX    3'h6

// sequence output behaviours
`define STIO_SEQ_HIGH    2'h0
`define STIO_SEQ_LOW     2'h1
`define STIO_SEQ_PHIGH   2'h2
`define STIO_SEQ_PLOW    2'h3

// branch opcodes
`define STIO_OP_NEXT     3'h0
`define STIO_OP_IN_HIGH  3'h1
`define STIO_OP_IN_LOW   3'h2
`define STIO_OP_PASS     3'h3
`define STIO_OP_FAIL     3'h4
`define STIO_OP_CALL     3'h5

// status field positions
`define STIO_ST_BUSY     0
`define STIO_ST_PEND     1
`define STIO_ST_HOLD     2
`define STIO_ST_ERR      3
`define STIO_ST_LIMIT    4

// timing
`define STIO_CLK_NS      4
`define STIO_PULSE_NS    1000
`define STIO_PULSE_CYC   (`STIO_PULSE_NS / `STIO_CLK_NS)

// axi responses
`define STIO_RESP_OKAY   2'h0
`define STIO_RESP_SLVERR 2'h2

`endif

/* verilog/stio_branch_eval.v */
`include "stio_map.vh"
`default_nettype none

module stio_branch_eval (
   input  wire [2:0] op,
   input  wire [2:0] dest,
   input  wire [5:0] loaded,
   input  wire       gpio_mode,
   input  wire [4:0] in_lines,
   input  wire [2:0] sel,
   input  wire       limit_pass,
   output reg        taken,
   output reg        fault
);

   reg cond;
   reg dest_ok;

   always @* begin
      cond    = 1'b0;
      dest_ok = 1'b0;
      case (op)
         `STIO_OP_IN_HIGH: cond = gpio_mode & in_lines[sel];   // [RL6] [RL22]
         `STIO_OP_IN_LOW:  cond = gpio_mode & ~in_lines[sel];  // [RL7] [RL22]
         `STIO_OP_PASS:    cond = limit_pass;                  // [RL21]
         `STIO_OP_FAIL:    cond = ~limit_pass;                 // [RL21]
         `STIO_OP_CALL:    cond = 1'b1;
         default:          cond = 1'b0;
      endcase
      // target chosen purely by slot number [RL18]
      if (dest >= `STIO_SLOT_MIN && dest <= `STIO_SLOT_MAX) begin
         dest_ok = loaded[dest - 3'h1];                        // [RL20]
      end
      // an empty or out-of-range slot never gets jumped to
      taken = cond & dest_ok;
      fault = cond & ~dest_ok;
   end

endmodule

`default_nettype wire

/* verilog/stio_ttl_port.v */
// How it works
// (RL1) a whole-byte write drives all eight output lines with the value 0..255.
// (RL2) set command drives the indexed output line (0..7) high, others unchanged.
// (RL3) clear command drives the indexed output line (0..7) low, others unchanged.
// (RL4) five input lines are sampled for use as branch conditions.
// (RL5) input selector holds 0..4 and picks the line branch tests examine.
// (RL6) branch-on-high jumps only when the selected input is high, else next command.
// (RL7) branch-on-low jumps only when the selected input is low, else next command.
// (RL8) accessory code top line is high for codes 4..7.
// (RL9) accessory code bottom line is high for odd codes.
// (RL10) accessory code middle line is high for codes 2, 3, 6, 7.
// (RL11) valid strobe is low while the three code lines are valid.
// (RL12) direction line high for forward, low for reverse.
// (RL13) separate forward and reverse codes; the active one follows direction.
// (RL14) forward code resets to seven; six drops bottom line, seven restores.
// (RL15) no new sweep starts while the hold-off input is asserted.
// (RL16) interconnect repeats the sequence output line and the limit result.
// (RL17) sequence output is static high, static low, high pulse or low pulse.
// (RL18) branches target a numbered slot 1..6, never a title.
// (RL19) branch to the running slot restarts it from its first command.
// (RL20) a taken branch never returns; the target slot must be loaded.
// (RL21) pass/fail branches jump only when the limit result matches.
// (RL22) input branches are evaluated only in general purpose mode.
// (RL23) port runs in exactly one of printer or general purpose mode.
// (RL24) output lines keep their level until a later write, set or clear.
// (RL25) end-of-sweep pulse lasts a fixed cycle count, then returns idle.
// (RL26) input lines pass a two-stage synchroniser before any branch decision.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`include "stio_map.vh"
`default_nettype none

module stio_ttl_port #(
   parameter ADDR_W       = 8,
   parameter CNT_W        = 16,
   parameter PULSE_CYCLES = `STIO_PULSE_CYC
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   output wire [1:0]        s_axi_bresp,
   output wire              s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   output wire [31:0]       s_axi_rdata,
   output wire [1:0]        s_axi_rresp,
   output wire              s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire [4:0]        in_lines_i,
   input  wire              sweep_holdoff_i,
   input  wire              sweep_done_i,
   input  wire              limit_pass_i,
   output wire [7:0]        out_lines_o,
   output wire              gpio_mode_o,
   output wire [2:0]        acc_code_o,
   output wire              acc_valid_n_o,
   output wire              dir_fwd_o,
   output wire              seq_out_o,
   output wire              ic_seq_out_o,
   output wire              ic_limit_o,
   output wire              sweep_start_o
);

   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_ARM  = 3'b010;
   localparam [2:0] S_RUN  = 3'b100;
   localparam [CNT_W-1:0] PULSE_LEN = PULSE_CYCLES[CNT_W-1:0];

   // bus slave state
   reg              awready_reg;
   reg              wready_reg;
   reg              bvalid_reg;
   reg [1:0]        bresp_reg;
   reg [ADDR_W-1:0] awaddr_reg;
   reg [31:0]       wdata_reg;
   reg [3:0]        wstrb_reg;
   reg              arready_reg;
   reg              rvalid_reg;
   reg [1:0]        rresp_reg;
   reg [31:0]       rdata_reg;
   reg [31:0]       rdata_next;
   reg              rmapped;
   reg              wmapped;

   // block state
   reg              gpio_mode_reg;
   reg [7:0]        out_reg;
   reg [2:0]        sel_reg;
   reg [2:0]        acc_fwd_reg;
   reg [2:0]        acc_rev_reg;
   reg [2:0]        acc_code_reg;
   reg              acc_valid_n_reg;
   reg              dir_fwd_reg;
   reg [1:0]        seq_mode_reg;
   reg              seq_out_reg;
   reg              ic_seq_out_reg;
   reg              ic_limit_reg;
   reg [CNT_W-1:0]  pulse_cnt_reg;
   reg [CNT_W-1:0]  pulse_cnt_next;
   reg              seq_out_next;
   reg [2:0]        sweep_state_reg;
   reg              sweep_start_reg;
   reg [5:0]        slots_reg;
   reg [2:0]        cur_slot_reg;
   reg [7:0]        cmd_idx_reg;
   reg              last_taken_reg;
   reg              branch_err_reg;
   reg [4:0]        in_meta_reg;
   reg [4:0]        in_sync_reg;
   reg              hold_meta_reg;
   reg              hold_sync_reg;

   wire             wr_fire;
   wire             wr_low;
   wire [7:0]       out_next;
   wire [2:0]       code_next;
   wire             br_taken;
   wire             br_fault;
   wire             br_cmd;

   // write happens once both address and data are held and no response is pending
   assign wr_fire = ~awready_reg & ~wready_reg & ~bvalid_reg;
   assign wr_low  = wr_fire & wstrb_reg[0];
   assign br_cmd  = wr_low & (awaddr_reg == `STIO_BRANCH_CMD);

   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;

   assign out_lines_o   = out_reg;
   assign gpio_mode_o   = gpio_mode_reg;
   assign acc_code_o    = acc_code_reg;
   assign acc_valid_n_o = acc_valid_n_reg;
   assign dir_fwd_o     = dir_fwd_reg;
   assign seq_out_o     = seq_out_reg;
   assign ic_seq_out_o  = ic_seq_out_reg;
   assign ic_limit_o    = ic_limit_reg;
   assign sweep_start_o = sweep_start_reg;

   // write channel handshakes
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `STIO_RESP_OKAY;
         awaddr_reg  <= {ADDR_W{1'b0}};
         wdata_reg   <= 32'h0;
         wstrb_reg   <= 4'h0;
      end else begin
         if (awready_reg && s_axi_awvalid) begin
            awready_reg <= 1'b0;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (wready_reg && s_axi_wvalid) begin
            wready_reg <= 1'b0;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wmapped ? `STIO_RESP_OKAY : `STIO_RESP_SLVERR;
         end
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   always @* begin
      case (awaddr_reg)
         `STIO_PORT_MODE, `STIO_OUT_BYTE, `STIO_OUT_SET, `STIO_OUT_CLR,
         `STIO_IN_LEVELS, `STIO_IN_SEL, `STIO_ACC_FWD, `STIO_ACC_REV,
         `STIO_DIRECTION, `STIO_SEQ_OUT_CFG, `STIO_SWEEP, `STIO_BRANCH_CMD,
         `STIO_SEQ_STATE, `STIO_SLOTS: wmapped = 1'b1;
         default:                      wmapped = 1'b0;
      endcase
   end

   // read channel
   always @* begin
      rmapped    = 1'b1;
      rdata_next = 32'h0;
      case (s_axi_araddr)
         `STIO_PORT_MODE:   rdata_next[0]   = gpio_mode_reg;
         `STIO_OUT_BYTE:    rdata_next[7:0] = out_reg;
         `STIO_OUT_SET:     rdata_next[7:0] = out_reg;
         `STIO_OUT_CLR:     rdata_next[7:0] = out_reg;
         `STIO_IN_LEVELS:   rdata_next[4:0] = in_sync_reg;
         `STIO_IN_SEL:      rdata_next[2:0] = sel_reg;
         `STIO_ACC_FWD:     rdata_next[2:0] = acc_fwd_reg;
         `STIO_ACC_REV:     rdata_next[2:0] = acc_rev_reg;
         `STIO_DIRECTION:   rdata_next[0]   = dir_fwd_reg;
         `STIO_SEQ_OUT_CFG: rdata_next[1:0] = seq_mode_reg;
         `STIO_SWEEP: begin
            rdata_next[`STIO_ST_BUSY]  = sweep_state_reg[2];
            rdata_next[`STIO_ST_PEND]  = sweep_state_reg[1];
            rdata_next[`STIO_ST_HOLD]  = hold_sync_reg;
            rdata_next[`STIO_ST_ERR]   = branch_err_reg;
            rdata_next[`STIO_ST_LIMIT] = limit_pass_i;
         end
         `STIO_BRANCH_CMD:  rdata_next      = 32'h0;
         `STIO_SEQ_STATE:   rdata_next      = {16'h0, cmd_idx_reg, 4'h0, last_taken_reg, cur_slot_reg};
         `STIO_SLOTS:       rdata_next[5:0] = slots_reg;
         default:           rmapped         = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= `STIO_RESP_OKAY;
         rdata_reg   <= 32'h0;
      end else begin
         if (arready_reg && s_axi_arvalid) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rmapped ? `STIO_RESP_OKAY : `STIO_RESP_SLVERR;
         end
         if (rvalid_reg && s_axi_rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // in_lines_i and sweep_holdoff_i cross in through two flops; only the second is ever read
   always @(posedge aclk) begin
      if (!aresetn) begin
         in_meta_reg   <= 5'h0;
         in_sync_reg   <= 5'h0;
         hold_meta_reg <= 1'b0;
         hold_sync_reg <= 1'b0;
      end else begin
         in_meta_reg   <= in_lines_i;     // [RL26]
         in_sync_reg   <= in_meta_reg;    // [RL4] [RL26]
         hold_meta_reg <= sweep_holdoff_i;
         hold_sync_reg <= hold_meta_reg;
      end
   end

   // per-line output update; untouched lines keep their level
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_out
         assign out_next[gi] =
            (wr_low && awaddr_reg == `STIO_OUT_BYTE) ? wdata_reg[gi] :                     // [RL1]
            (wr_low && awaddr_reg == `STIO_OUT_SET && wdata_reg[2:0] == gi) ? 1'b1 :       // [RL2]
            (wr_low && awaddr_reg == `STIO_OUT_CLR && wdata_reg[2:0] == gi) ? 1'b0 :       // [RL3]
            out_reg[gi];                                                                   // [RL24]
      end
   endgenerate

   // configuration registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         gpio_mode_reg <= 1'b0;
         out_reg       <= 8'h0;
         sel_reg       <= 3'h0;
         acc_fwd_reg   <= `STIO_ACC_RST;   // [RL14]
         acc_rev_reg   <= `STIO_ACC_RST;
         dir_fwd_reg   <= 1'b1;
         seq_mode_reg  <= `STIO_SEQ_HIGH;
         slots_reg     <= 6'h0;
      end else begin
         out_reg <= out_next;
         if (wr_low) begin
            case (awaddr_reg)
               `STIO_PORT_MODE:   gpio_mode_reg <= wdata_reg[0];            // [RL23]
               `STIO_IN_SEL: begin
                  if (wdata_reg[2:0] <= `STIO_SEL_MAX) begin
                     sel_reg <= wdata_reg[2:0];                             // [RL5]
                  end
               end
               `STIO_ACC_FWD:     acc_fwd_reg   <= wdata_reg[2:0];          // [RL14]
               `STIO_ACC_REV:     acc_rev_reg   <= wdata_reg[2:0];          // [RL13]
               `STIO_DIRECTION:   dir_fwd_reg   <= wdata_reg[0];            // [RL12]
               `STIO_SEQ_OUT_CFG: seq_mode_reg  <= wdata_reg[1:0];          // [RL17]
               `STIO_SLOTS:       slots_reg     <= wdata_reg[5:0];
               default:           slots_reg     <= slots_reg;
            endcase
         end
      end
   end

   // accessory code follows the active direction; strobe goes high for the
   // one cycle in which the lines change so a latch never catches a mix
   assign code_next = dir_fwd_reg ? acc_fwd_reg : acc_rev_reg;   // [RL13]

   always @(posedge aclk) begin
      if (!aresetn) begin
         acc_code_reg    <= `STIO_ACC_RST;
         acc_valid_n_reg <= 1'b1;
      end else begin
         acc_code_reg[2] <= code_next[2];   // [RL8]
         acc_code_reg[1] <= code_next[1];   // [RL10]
         acc_code_reg[0] <= code_next[0];   // [RL9]
         acc_valid_n_reg <= (code_next != acc_code_reg);   // [RL11]
      end
   end

   // sweep start control
   always @(posedge aclk) begin
      if (!aresetn) begin
         sweep_state_reg <= S_IDLE;
         sweep_start_reg <= 1'b0;
      end else begin
         sweep_start_reg <= 1'b0;
         case (sweep_state_reg)
            S_IDLE: begin
               if (wr_low && awaddr_reg == `STIO_SWEEP && wdata_reg[0]) begin
                  sweep_state_reg <= S_ARM;
               end
            end
            S_ARM: begin
               if (!hold_sync_reg) begin              // [RL15]
                  sweep_state_reg <= S_RUN;
                  sweep_start_reg <= 1'b1;
               end
            end
            S_RUN: begin
               if (sweep_done_i) begin
                  sweep_state_reg <= S_IDLE;
               end
            end
            default: sweep_state_reg <= S_IDLE;
         endcase
      end
   end

   // sequence output line; pulse length is counted so idle level returns on time
   always @* begin
      if (sweep_done_i) begin
         pulse_cnt_next = PULSE_LEN;                                     // [RL25]
      end else if (pulse_cnt_reg != {CNT_W{1'b0}}) begin
         pulse_cnt_next = pulse_cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};     // [RL25]
      end else begin
         pulse_cnt_next = {CNT_W{1'b0}};
      end
      case (seq_mode_reg)
         `STIO_SEQ_HIGH:  seq_out_next = 1'b1;                             // [RL17]
         `STIO_SEQ_LOW:   seq_out_next = 1'b0;                             // [RL17]
         `STIO_SEQ_PHIGH: seq_out_next = (pulse_cnt_next != {CNT_W{1'b0}});  // [RL17]
         default:         seq_out_next = (pulse_cnt_next == {CNT_W{1'b0}});  // [RL17]
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         pulse_cnt_reg  <= {CNT_W{1'b0}};
         seq_out_reg    <= 1'b1;
         ic_seq_out_reg <= 1'b1;
         ic_limit_reg   <= 1'b0;
      end else begin
         pulse_cnt_reg  <= pulse_cnt_next;
         seq_out_reg    <= seq_out_next;
         ic_seq_out_reg <= seq_out_next;   // [RL16]
         ic_limit_reg   <= limit_pass_i;   // [RL16]
      end
   end

   stio_branch_eval u_eval (
      .op         (wdata_reg[2:0]),
      .dest       (wdata_reg[6:4]),
      .loaded     (slots_reg),
      .gpio_mode  (gpio_mode_reg),
      .in_lines   (in_sync_reg),
      .sel        (sel_reg),
      .limit_pass (limit_pass_i),
      .taken      (br_taken),
      .fault      (br_fault)
   );

   // sequence position tracker; a jump is one-way, so no return slot is kept
   always @(posedge aclk) begin
      if (!aresetn) begin
         cur_slot_reg   <= `STIO_SLOT_MIN;
         cmd_idx_reg    <= 8'h0;
         last_taken_reg <= 1'b0;
         branch_err_reg <= 1'b0;
      end else begin
         if (br_cmd) begin
            last_taken_reg <= br_taken;
            if (br_taken) begin
               cur_slot_reg <= wdata_reg[6:4];   // [RL18] [RL20]
               cmd_idx_reg  <= 8'h0;             // [RL19]
            end else begin
               cmd_idx_reg  <= cmd_idx_reg + 8'h1;   // [RL6] [RL7]
            end
         end
         // a new fault wins over a clear in the same write
         if (br_cmd && br_fault) begin
            branch_err_reg <= 1'b1;              // [RL20]
         end else if (wr_low && awaddr_reg == `STIO_SWEEP && wdata_reg[`STIO_ST_ERR]) begin
            branch_err_reg <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

/* dv/stio_fixture.sv */
`default_nettype none
module stio_fixture #(
   parameter int DONE_DLY = 3
) (
   input  wire logic       aclk,
   input  wire logic       sweep_start_o,
   input  wire logic [4:0] lines_set,
   input  wire logic       hold_set,
   input  wire logic       pass_set,
   output var  logic [4:0] in_lines_i,
   output var  logic       sweep_holdoff_i,
   output var  logic       sweep_done_i,
   output var  logic       limit_pass_i
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   always @(posedge aclk) begin
      in_lines_i <= lines_set;
      sweep_holdoff_i <= hold_set;
      limit_pass_i <= pass_set;
      sweep_done_i <= (cnt == 1);
      if (sweep_start_o) begin
         cnt <= DONE_DLY;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

/* dv/stio_ttl_port_properties.sv */
`default_nettype none
module stio_props (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       limit_pass_i,
   input wire logic       sweep_holdoff_i,
   input wire logic [7:0] out_lines_o,
   input wire logic       gpio_mode_o,
   input wire logic [2:0] acc_code_o,
   input wire logic       acc_valid_n_o,
   input wire logic       dir_fwd_o,
   input wire logic       seq_out_o,
   input wire logic       ic_seq_out_o,
   input wire logic       ic_limit_o,
   input wire logic       sweep_start_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic bv1, bv2;
   always_ff @(posedge aclk) begin
      bv1 <= s_axi_bvalid;
      bv2 <= bv1;
   end
   sequence strobe_blip; acc_valid_n_o ##1 !acc_valid_n_o; endsequence
   sequence start_blip; sweep_start_o ##1 !sweep_start_o; endsequence
   sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   ic_seq_copy_a: assert property (ic_seq_out_o == seq_out_o)
      else $error("interconnect sequence copy differs");
   ic_limit_copy_a: assert property ($past(aresetn) |-> ic_limit_o == $past(limit_pass_i))
      else $error("interconnect limit copy differs");
   strobe_blip_a: assert property (acc_valid_n_o |-> strobe_blip)
      else $error("valid strobe high too long");
   strobe_cause_a: assert property ($past(aresetn) && acc_valid_n_o |-> $changed(acc_code_o))
      else $error("valid strobe high without code change");
   code_after_write_a: assert property ($changed(acc_code_o) |-> bv1 && !bv2)
      else $error("accessory code changed without write");
   out_hold_a: assert property ($changed(out_lines_o) |-> $rose(s_axi_bvalid))
      else $error("output byte changed without write");
   mode_hold_a: assert property ($changed(gpio_mode_o) || $changed(dir_fwd_o) |-> $rose(s_axi_bvalid))
      else $error("mode or direction changed without write");
   start_pulse_a: assert property (sweep_start_o |-> start_blip)
      else $error("sweep start longer than one cycle");
   holdoff_block_a: assert property (sweep_holdoff_i [*5] |=> !sweep_start_o)
      else $error("sweep started during hold-off");
   write_answer_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response late");
endmodule
bind stio_ttl_port stio_props chk (.*);
`default_nettype wire

/* dv/test_sequencer_ttl_io_port.sv */
`include "stio_map.vh"
`default_nettype none
module test_sequencer_ttl_io_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 0, aresetn = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [4:0]  lset = 0;
   logic        hset = 0, pset = 0;
   wire logic   awready, wready, bvalid, arready, rvalid, gpio, accv_n, dir, seqo, icseq, iclim, start;
   wire logic   hold, done, lim;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [7:0]  outl;
   wire logic [2:0]  acc;
   wire logic [4:0]  inl;
   int          num_errors = 0, checks_done = 0, cyc = 0;
   initial forever #2 aclk = ~aclk;
   stio_ttl_port #(.PULSE_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .in_lines_i(inl), .sweep_holdoff_i(hold), .sweep_done_i(done), .limit_pass_i(lim),
      .out_lines_o(outl), .gpio_mode_o(gpio), .acc_code_o(acc), .acc_valid_n_o(accv_n), .dir_fwd_o(dir),
      .seq_out_o(seqo), .ic_seq_out_o(icseq), .ic_limit_o(iclim), .sweep_start_o(start));
   stio_fixture fix (.aclk(aclk), .sweep_start_o(start), .lines_set(lset), .hold_set(hset),
      .pass_set(pset), .in_lines_i(inl), .sweep_holdoff_i(hold), .sweep_done_i(done), .limit_pass_i(lim));
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      bready <= 0;
      chk("bresp", er, bresp);
      #1;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      rready <= 0;
      chk("rdata", e, rdata);
      chk("rresp", er, rresp);
      #1;
   endtask
   task brc(input logic [2:0] op, input logic [2:0] ds, input logic [7:0] ix, input logic t, input logic [2:0] sl);
      wr(`STIO_BRANCH_CMD, {25'h0, ds, 1'b0, op});
      rchk(`STIO_SEQ_STATE, {16'h0, ix, 4'h0, t, sl});
   endtask
   task pulse(input logic lv);
      int n;
      n = 0;
      while (seqo !== lv) tick(1);
      while (seqo === lv) begin tick(1); n++; end
      chk("pulse width", 4, n);
   endtask
   task t_reset;
      chk("acc", 7, acc); chk("dir", 1, dir); chk("valid_n", 0, accv_n); chk("out", 0, outl);
      rchk(`STIO_ACC_FWD, 7); rchk(`STIO_ACC_REV, 7); rchk(`STIO_SEQ_STATE, 1); rchk(`STIO_SLOTS, 0);
      rchk(8'h2c, 0, `STIO_RESP_SLVERR);
      wr(8'h2c, 1, `STIO_RESP_SLVERR);
      $display("test reset done");
   endtask
   task t_out;
      logic [7:0] v[3] = '{8'hff, 8'h00, 8'h5a};
      logic [7:0] e;
      for (int i = 0; i < 3; i++) begin wr(`STIO_OUT_BYTE, v[i]); chk("out", v[i], outl); end
      e = 8'h5a;
      for (int i = 0; i < 8; i++) begin
         e[i] = 1'b1;
         wr(`STIO_OUT_SET, i); chk("out set", e, outl);
         e[(i + 3) % 8] = 1'b0;
         wr(`STIO_OUT_CLR, (i + 3) % 8); chk("out clr", e, outl);
      end
      rchk(`STIO_OUT_SET, e);
      $display("test output byte done");
   endtask
   task t_acc;
      for (int c = 0; c < 8; c++) begin wr(`STIO_ACC_FWD, c); chk("acc", c, acc); end
      wr(`STIO_ACC_FWD, 6); chk("acc low line", 0, acc[0]);
      wr(`STIO_ACC_FWD, 7); chk("acc low line", 1, acc[0]);
      wr(`STIO_ACC_REV, 2); chk("acc", 7, acc);
      wr(`STIO_DIRECTION, 0); chk("dir", 0, dir); chk("acc", 2, acc);
      wr(`STIO_DIRECTION, 1); chk("dir", 1, dir); chk("acc", 7, acc);
      $display("test accessory done");
   endtask
   task t_branch;
      wr(`STIO_SLOTS, 32'h3f); wr(`STIO_IN_SEL, 2);
      @(posedge aclk); lset <= 5'h04; tick(5);
      rchk(`STIO_IN_LEVELS, 4);
      brc(1, 3, 1, 0, 1);
      wr(`STIO_PORT_MODE, 1); chk("gpio", 1, gpio);
      brc(1, 3, 0, 1, 3);
      brc(2, 5, 1, 0, 3);
      wr(`STIO_IN_SEL, 5); rchk(`STIO_IN_SEL, 2);
      brc(1, 3, 0, 1, 3);
      @(posedge aclk); lset <= 5'h00; pset <= 1; tick(5);
      brc(2, 2, 0, 1, 2);
      brc(4, 6, 1, 0, 2);
      brc(3, 6, 0, 1, 6);
      rchk(`STIO_SWEEP, 32'h10);
      wr(`STIO_SLOTS, 32'h1f); brc(5, 6, 1, 0, 6); rchk(`STIO_SWEEP, 32'h18);
      wr(`STIO_SWEEP, 8); rchk(`STIO_SWEEP, 32'h10);
      brc(5, 0, 2, 0, 6); rchk(`STIO_SWEEP, 32'h18);
      wr(`STIO_SWEEP, 8);
      $display("test branch done");
   endtask
   task t_sweep;
      logic seen;
      seen = 0;
      wr(`STIO_SEQ_OUT_CFG, 0); chk("seq", 1, seqo); chk("ic limit", 1, iclim);
      wr(`STIO_SEQ_OUT_CFG, 1); chk("seq", 0, seqo); chk("ic seq", 0, icseq);
      wr(`STIO_SEQ_OUT_CFG, 2);
      @(posedge aclk); hset <= 1; tick(5);
      wr(`STIO_SWEEP, 1);
      for (int i = 0; i < 20; i++) begin tick(1); seen |= start; end
      chk("start under hold", 0, seen);
      rchk(`STIO_SWEEP, 32'h16);
      @(posedge aclk); hset <= 0;
      pulse(1);
      wr(`STIO_SEQ_OUT_CFG, 3); wr(`STIO_SWEEP, 1);
      pulse(0);
      $display("test sweep done");
   endtask
   task results;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         results;
      end
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      tick(1);
      t_reset;
      t_out;
      t_acc;
      t_branch;
      t_sweep;
      results;
   end
endmodule
`default_nettype wire
